// ==== debounce_filter.sv ====
`timescale 1ns/10ps
module debounce_filter #(
	parameter int W = 1,
	parameter int CW = 2
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic i_sample,
	input wire logic [W-1:0] i_raw,
	input wire logic [CW-1:0] i_need,
	output logic [W-1:0] o_stable,
	output logic o_changed
);
	logic [W-1:0] cand; // Value now being confirmed
	logic [W-1:0] next_cand;
	logic [CW-1:0] cnt; // Consistent samples of cand so far
	logic [CW-1:0] next_cnt;
	logic [W-1:0] next_stable;
	logic next_changed;
	logic [CW-1:0] cnt_inc;

	// ----------------------------------------------------------------------
	// Confirmation counter
	// ----------------------------------------------------------------------
	// A need of zero is treated as one, so acceptance is on the next sample
	always_comb begin
		next_stable = o_stable;
		next_cand = cand;
		next_cnt = cnt;
		next_changed = 1'b0;
		cnt_inc = (i_raw == cand) ? cnt + CW'(1) : CW'(1);
		if (!i_enable) begin
			next_stable = '0;
			next_cand = '0;
			next_cnt = '0;
		end else if (i_sample) begin
			if (i_raw == o_stable) begin
				// Bounce back to the held value restarts the count
				next_cand = o_stable;
				next_cnt = '0;
			end else if (cnt_inc >= i_need) begin
				next_stable = i_raw;
				next_cand = i_raw;
				next_cnt = '0;
				next_changed = 1'b1;
			end else begin
				next_cand = i_raw;
				next_cnt = cnt_inc;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_stable <= '0;
			cand <= '0;
			cnt <= '0;
			o_changed <= 1'b0;
		end else begin
			o_stable <= next_stable;
			cand <= next_cand;
			cnt <= next_cnt;
			o_changed <= next_changed;
		end
	end

	property p_update_on_sample;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_stable != $past(o_stable) && $past(i_enable)) |-> $past(i_sample);
	endproperty
	a_update_on_sample: assert property (p_update_on_sample) else $error("stable moved off sample");

	property p_no_early_accept;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_enable && i_sample && i_raw != o_stable && cnt_inc < i_need) |=>
			(o_stable == $past(o_stable));
	endproperty
	a_no_early_accept: assert property (p_no_early_accept) else $error("accepted before count");

endmodule : debounce_filter

// ==== detect_tick.sv ====
`timescale 1ns/10ps
module detect_tick import jack_pkg::*; #(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic [1:0] i_period_sel,
	output logic o_ms_tick,
	output logic o_det_tick
);
	localparam int MSW = $clog2(MS_CYCLES_P);

	logic [MSW-1:0] ms_cnt; // Cycles within the current millisecond
	logic [MSW-1:0] next_ms_cnt;
	logic [1:0] ms_div; // Milliseconds within a detection period
	logic [1:0] next_ms_div;
	logic next_ms_tick;
	logic next_det_tick;
	logic ms_end;

	// ----------------------------------------------------------------------
	// Millisecond and detection-period enables
	// ----------------------------------------------------------------------
	// Counters rest while detection is off so the first period is whole
	always_comb begin
		ms_end = (ms_cnt == MSW'(MS_CYCLES_P - 1));
		next_ms_cnt = ms_end ? '0 : ms_cnt + MSW'(1);
		next_ms_div = ms_div;
		next_ms_tick = 1'b0;
		next_det_tick = 1'b0;
		if (!i_enable) begin
			next_ms_cnt = '0;
			next_ms_div = '0;
		end else if (ms_end) begin
			next_ms_tick = 1'b1;
			next_ms_div = ms_div + 2'h1;
			// Reserved code 3 runs at the slowest period
			unique case (i_period_sel)
				DET_PERIOD_1MS: next_det_tick = 1'b1;
				DET_PERIOD_2MS: next_det_tick = ms_div[0];
				default: next_det_tick = (ms_div == 2'h3);
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ms_cnt <= '0;
			ms_div <= '0;
			o_ms_tick <= 1'b0;
			o_det_tick <= 1'b0;
		end else begin
			ms_cnt <= next_ms_cnt;
			ms_div <= next_ms_div;
			o_ms_tick <= next_ms_tick;
			o_det_tick <= next_det_tick;
		end
	end

	property p_tick_1ms;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_enable && i_period_sel == DET_PERIOD_1MS && $past(i_enable) &&
			$past(i_period_sel) == DET_PERIOD_1MS) |-> (o_det_tick == o_ms_tick);
	endproperty
	a_tick_1ms: assert property (p_tick_1ms) else $error("1 ms period tick mismatch");

endmodule : detect_tick

// ==== jack_detect_and_activity_cfg.sv ====
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Headphone result: immediate or three consistent detections
// - Insertion debounce 16 to 512 ms, or none
// - Removal confirmed after five or three detections
// - Hook press: none, two or three detections
// - Jack type status: none, no mic, mic
// - Headset type status: none, right, left, stereo
// - Power mode: user, auto, auto up only
// - Monitor channel select, reset selects channel two
// - Data-out pin carries interrupt when not recording
// - Detection while recording only when enabled
// - Tone generator output channel select
// - Headset detection runs only while enable bit set
// - Detection period 1, 2 or 4 ms
module jack_detect_and_activity_cfg import jack_pkg::*; #(
	parameter int MS_CYCLES_P = MS_CYCLES
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_N,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WR_DATA,
	input wire logic I_WR_STB,
	input wire logic I_RD_STB,
	input wire logic I_JACK_PRESENT,
	input wire logic I_MIC_PRESENT,
	input wire logic [1:0] I_HEADSET_KIND,
	input wire logic I_HOOK_RAW,
	input wire logic I_ACTIVITY_EVENT,
	input wire logic I_ACTIVITY_IDLE,
	input wire logic I_RECORDING,
	input wire logic I_USER_POWER_UP,
	input wire logic I_USER_POWER_DOWN,
	input wire logic I_SERIAL_DATA,
	output logic [7:0] O_RD_DATA,
	output logic [1:0] O_MONITOR_CHANNEL,
	output logic [1:0] O_TONE_CHANNEL,
	output logic O_ADC_POWER_UP,
	output logic O_HOOK_PRESSED,
	output logic O_DOUT,
	output logic O_DOUT_OE,
	output logic O_IRQ
);

	// ----------------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------------
	// Analog comparator outputs are asynchronous to the core clock
	logic [4:0] pin_meta; // First stage, read only by second stage
	logic [4:0] pin_sync; // Second stage, safe to use
	logic jack_raw;
	logic mic_raw;
	logic [1:0] kind_raw;
	logic hook_raw;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {I_HOOK_RAW, I_HEADSET_KIND, I_MIC_PRESENT, I_JACK_PRESENT};
			pin_sync <= pin_meta;
		end
	end

	assign jack_raw = pin_sync[0];
	assign mic_raw = pin_sync[1];
	assign kind_raw = pin_sync[3:2];
	assign hook_raw = pin_sync[4];

	// ----------------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------------
	logic [7:0] clock_cfg; // Detection period select
	logic [7:0] detect_ctrl; // Detection enable
	jack_debounce_s debounce; // Debounce settings
	activity_cfg_s activity; // Activity detect setup
	logic [7:0] tone; // Tone generator setup
	logic [IRQ_BITS-1:0] irq_status; // Sticky events
	logic [IRQ_BITS-1:0] irq_mask; // Event enables
	logic [7:0] next_clock_cfg;
	logic [7:0] next_detect_ctrl;
	jack_debounce_s next_debounce;
	activity_cfg_s next_activity;
	logic [7:0] next_tone;
	logic [IRQ_BITS-1:0] next_irq_status;
	logic [IRQ_BITS-1:0] next_irq_mask;
	logic [7:0] next_rd_data;
	logic [7:0] jack_status; // Live jack and headset type
	logic [IRQ_BITS-1:0] events; // One-cycle event pulses

	// ----------------------------------------------------------------------
	// Detection blocks
	// ----------------------------------------------------------------------
	logic detect_en; // Headset detection enabled
	logic ms_tick;
	logic det_tick;
	logic inserted; // Debounced jack presence
	logic jack_changed;
	logic [9:0] jack_need;
	logic jack_sample;
	logic [2:0] phone_stable; // {mic, headset kind}
	logic phone_changed;
	logic [1:0] phone_need;
	logic hook_stable;
	logic hook_changed;
	logic [1:0] hook_need;
	logic [1:0] jack_type;
	logic [2:0] insert_code;

	assign detect_en = detect_ctrl[DETECT_EN_BIT];

	detect_tick #(
		.MS_CYCLES_P(MS_CYCLES_P)
	) u_tick (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_enable(detect_en),
		.i_period_sel(clock_cfg[CLK_SEL_LSB+1:CLK_SEL_LSB]),
		.o_ms_tick(ms_tick),
		.o_det_tick(det_tick)
	);

	// Insertion is timed in milliseconds, removal counted in detections.
	// Reserved code 6 falls back to the longest insertion time.
	always_comb begin
		insert_code = debounce.insert_debounce_time;
		if (insert_code > INSERT_MAX_CODE && insert_code != INSERT_NONE_CODE) begin
			insert_code = INSERT_MAX_CODE;
		end
		if (inserted) begin
			jack_sample = det_tick;
			jack_need = debounce.removal_debounce_count ? REMOVAL_COUNT_FAST
				: REMOVAL_COUNT_SLOW;
		end else if (insert_code == INSERT_NONE_CODE) begin
			jack_sample = det_tick;
			jack_need = 10'h001;
		end else begin
			jack_sample = ms_tick;
			jack_need = INSERT_BASE_MS << insert_code;
		end
	end

	debounce_filter #(
		.W(1),
		.CW(10)
	) u_jack (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_enable(detect_en),
		.i_sample(jack_sample),
		.i_raw(jack_raw),
		.i_need(jack_need),
		.o_stable(inserted),
		.o_changed(jack_changed)
	);

	assign phone_need = debounce.phone_detect_debounce ? PHONE_DEB_COUNT : 2'h1;

	debounce_filter #(
		.W(3),
		.CW(2)
	) u_phone (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_enable(detect_en && inserted),
		.i_sample(det_tick),
		.i_raw({mic_raw, kind_raw}),
		.i_need(phone_need),
		.o_stable(phone_stable),
		.o_changed(phone_changed)
	);

	// Codes 0 and 1 both mean accept on the first detection
	assign hook_need = (debounce.hook_debounce_count < HOOK_MIN_COUNT_CODE) ? 2'h1
		: debounce.hook_debounce_count;

	debounce_filter #(
		.W(1),
		.CW(2)
	) u_hook (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RST_N),
		.i_enable(detect_en && inserted && phone_stable[2]),
		.i_sample(det_tick),
		.i_raw(hook_raw),
		.i_need(hook_need),
		.o_stable(hook_stable),
		.o_changed(hook_changed)
	);

	// Code 2 of the jack type is never produced
	assign jack_type = !inserted ? 2'h0 : (phone_stable[2] ? 2'h3 : 2'h1);
	assign jack_status = {jack_type, phone_stable[1:0], 4'h0};
	assign O_HOOK_PRESSED = hook_stable;

	// ----------------------------------------------------------------------
	// Activity detection and converter power
	// ----------------------------------------------------------------------
	logic activity_ok; // Activity allowed to count right now
	logic idle_ok;
	logic adc_on;
	logic next_adc_on;

	assign activity_ok = I_ACTIVITY_EVENT && (!I_RECORDING || activity.detect_during_record);
	assign idle_ok = I_ACTIVITY_IDLE && (!I_RECORDING || activity.detect_during_record);

	// Reserved mode holds the present power state
	always_comb begin
		next_adc_on = adc_on;
		unique case (activity.activity_power_mode)
			PWR_USER: begin
				if (I_USER_POWER_UP) next_adc_on = 1'b1;
				else if (I_USER_POWER_DOWN) next_adc_on = 1'b0;
			end
			PWR_AUTO: begin
				if (activity_ok) next_adc_on = 1'b1;
				else if (idle_ok) next_adc_on = 1'b0;
			end
			PWR_AUTO_UP: begin
				if (activity_ok) next_adc_on = 1'b1;
				else if (I_USER_POWER_DOWN) next_adc_on = 1'b0;
			end
			PWR_RESERVED: next_adc_on = adc_on;
		endcase
	end

	// ----------------------------------------------------------------------
	// Register writes, reads and interrupt status
	// ----------------------------------------------------------------------
	assign events[IRQ_INSERT] = jack_changed && inserted;
	assign events[IRQ_REMOVE] = jack_changed && !inserted;
	assign events[IRQ_HOOK] = hook_changed && hook_stable;
	assign events[IRQ_KIND] = phone_changed;
	assign events[IRQ_ACTIVITY] = activity_ok;

	// Reserved positions are masked on write so they always read zero
	always_comb begin
		next_clock_cfg = clock_cfg;
		next_detect_ctrl = detect_ctrl;
		next_debounce = debounce;
		next_activity = activity;
		next_tone = tone;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		next_rd_data = 8'h00;
		if (I_WR_STB) begin
			unique case (I_ADDR)
				ADDR_CLOCK_CFG: next_clock_cfg = I_WR_DATA & WMASK_CLOCK_CFG;
				ADDR_DETECT_CTRL: next_detect_ctrl = I_WR_DATA & WMASK_DETECT_CTRL;
				ADDR_DEBOUNCE: next_debounce = I_WR_DATA & WMASK_DEBOUNCE;
				ADDR_ACTIVITY: next_activity = I_WR_DATA & WMASK_ACTIVITY;
				ADDR_TONE: next_tone = I_WR_DATA & WMASK_TONE;
				ADDR_IRQ_MASK: next_irq_mask = I_WR_DATA[IRQ_BITS-1:0];
				default: next_tone = tone;
			endcase
		end
		if (I_RD_STB) begin
			unique case (I_ADDR)
				ADDR_CLOCK_CFG: next_rd_data = clock_cfg;
				ADDR_DETECT_CTRL: next_rd_data = detect_ctrl;
				ADDR_DEBOUNCE: next_rd_data = debounce;
				ADDR_JACK_STATUS: next_rd_data = jack_status;
				ADDR_ACTIVITY: next_rd_data = activity;
				ADDR_TONE: next_rd_data = tone;
				ADDR_IRQ_STATUS: begin
					next_rd_data = {3'h0, irq_status};
					next_irq_status = '0;
				end
				ADDR_IRQ_MASK: next_rd_data = {3'h0, irq_mask};
				default: next_rd_data = 8'h00;
			endcase
		end
		// Events set after the read clear so a same-cycle event survives
		next_irq_status = next_irq_status | events;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			clock_cfg <= RST_CLOCK_CFG;
			detect_ctrl <= RST_DETECT_CTRL;
			debounce <= RST_DEBOUNCE;
			activity <= RST_ACTIVITY;
			tone <= RST_TONE;
			irq_mask <= RST_IRQ[IRQ_BITS-1:0];
			irq_status <= RST_IRQ[IRQ_BITS-1:0];
			O_RD_DATA <= 8'h00;
			adc_on <= 1'b0;
		end else begin
			clock_cfg <= next_clock_cfg;
			detect_ctrl <= next_detect_ctrl;
			debounce <= next_debounce;
			activity <= next_activity;
			tone <= next_tone;
			irq_mask <= next_irq_mask;
			irq_status <= next_irq_status;
			O_RD_DATA <= next_rd_data;
			adc_on <= next_adc_on;
		end
	end

	assign O_IRQ = |(irq_status & irq_mask);
	assign O_MONITOR_CHANNEL = activity.activity_monitor_channel;
	assign O_TONE_CHANNEL = tone[7:6];
	assign O_ADC_POWER_UP = adc_on;

	// ----------------------------------------------------------------------
	// Serial data-out pin
	// ----------------------------------------------------------------------
	// Recording always owns the pin; the interrupt only borrows it when idle
	logic next_dout;
	logic next_dout_oe;

	always_comb begin
		if (I_RECORDING) begin
			next_dout = I_SERIAL_DATA;
			next_dout_oe = 1'b1;
		end else begin
			next_dout = activity.dataout_irq_enable && O_IRQ;
			next_dout_oe = activity.dataout_irq_enable;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_DOUT <= 1'b0;
			O_DOUT_OE <= 1'b0;
		end else begin
			O_DOUT <= next_dout;
			O_DOUT_OE <= next_dout_oe;
		end
	end

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	property p_phone_nodeb;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(!debounce.phone_detect_debounce && detect_en && inserted && det_tick &&
			$past(detect_en)) |=> (phone_stable == $past({mic_raw, kind_raw}));
	endproperty
	a_phone_nodeb: assert property (p_phone_nodeb) else $error("no-debounce result late");

	// Removal is counted in detection ticks, five of them with the bit clear
	property p_removal_slow;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(inserted && !debounce.removal_debounce_count) |->
			(jack_need == REMOVAL_COUNT_SLOW && jack_sample == det_tick);
	endproperty
	a_removal_slow: assert property (p_removal_slow) else $error("removal count not five");

	property p_type_legal;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		jack_type != 2'h2;
	endproperty
	a_type_legal: assert property (p_type_legal) else $error("reserved jack type shown");

	property p_kind_removed;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(!inserted && $past(!inserted)) |-> (phone_stable[1:0] == 2'h0);
	endproperty
	a_kind_removed: assert property (p_kind_removed) else $error("kind without jack");

	property p_auto_up;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(activity.activity_power_mode == PWR_AUTO && activity_ok) |=> O_ADC_POWER_UP;
	endproperty
	a_auto_up: assert property (p_auto_up) else $error("auto power-up missed");

	property p_monitor_write;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_WR_STB && I_ADDR == ADDR_ACTIVITY) |=> (O_MONITOR_CHANNEL == $past(I_WR_DATA[5:4]));
	endproperty
	a_monitor_write: assert property (p_monitor_write) else $error("monitor channel not taken");

	property p_dout_quiet;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		($past(!I_RECORDING) && $past(!activity.dataout_irq_enable)) |-> (!O_DOUT && !O_DOUT_OE);
	endproperty
	a_dout_quiet: assert property (p_dout_quiet) else $error("data-out driven without enable");

	property p_record_block;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_RECORDING && !activity.detect_during_record && !irq_status[IRQ_ACTIVITY]) |=>
			!irq_status[IRQ_ACTIVITY];
	endproperty
	a_record_block: assert property (p_record_block) else $error("activity while recording");

	property p_tone_write;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_WR_STB && I_ADDR == ADDR_TONE) |=> (O_TONE_CHANNEL == $past(I_WR_DATA[7:6]));
	endproperty
	a_tone_write: assert property (p_tone_write) else $error("tone channel not taken");

	property p_status_reserved;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		(I_RD_STB && I_ADDR == ADDR_JACK_STATUS) |=> (O_RD_DATA[3:0] == 4'h0);
	endproperty
	a_status_reserved: assert property (p_status_reserved) else $error("reserved bits nonzero");

	property p_disable_clears;
		@(posedge I_CORE_CLK) disable iff (!I_RST_N)
		!detect_en |=> (!inserted && !hook_stable);
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("detection ran disabled");


endmodule : jack_detect_and_activity_cfg

// ==== jack_pkg.sv ====
package jack_pkg;

	// ----------------------------------------------------------------------
	// Register offsets (byte addresses on the control port)
	// ----------------------------------------------------------------------
	localparam logic [7:0] ADDR_CLOCK_CFG = 8'h19; // Detection clock period
	localparam logic [7:0] ADDR_DETECT_CTRL = 8'h1A; // Detection enable
	localparam logic [7:0] ADDR_DEBOUNCE = 8'h1B; // Debounce settings
	localparam logic [7:0] ADDR_JACK_STATUS = 8'h1C; // Jack and headset type
	localparam logic [7:0] ADDR_ACTIVITY = 8'h1E; // Activity detect setup
	localparam logic [7:0] ADDR_TONE = 8'h1F; // Tone generator setup
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30; // Sticky events
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h31; // Event mask

	// ----------------------------------------------------------------------
	// Reset values and writable bit masks
	// ----------------------------------------------------------------------
	localparam logic [7:0] RST_CLOCK_CFG = 8'h00;
	localparam logic [7:0] RST_DETECT_CTRL = 8'h00;
	localparam logic [7:0] RST_DEBOUNCE = 8'h00;
	localparam logic [7:0] RST_ACTIVITY = 8'h20;
	localparam logic [7:0] RST_TONE = 8'h80;
	localparam logic [7:0] RST_IRQ = 8'h00;
	localparam logic [7:0] WMASK_CLOCK_CFG = 8'h06;
	localparam logic [7:0] WMASK_DETECT_CTRL = 8'h02;
	localparam logic [7:0] WMASK_DEBOUNCE = 8'h7F;
	localparam logic [7:0] WMASK_ACTIVITY = 8'hFA;
	localparam logic [7:0] WMASK_TONE = 8'hC0;
	localparam logic [7:0] WMASK_IRQ = 8'h1F;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int DETECT_EN_BIT = 1; // Headset detection enable
	localparam int CLK_SEL_LSB = 1; // Detection period select, two bits
	localparam int IRQ_INSERT = 0; // Jack inserted
	localparam int IRQ_REMOVE = 1; // Jack removed
	localparam int IRQ_HOOK = 2; // Hook button pressed
	localparam int IRQ_KIND = 3; // Headset type changed
	localparam int IRQ_ACTIVITY = 4; // Activity seen
	localparam int IRQ_BITS = 5;

	// ----------------------------------------------------------------------
	// Timing and counts
	// ----------------------------------------------------------------------
	localparam int CORE_CLK_HZ = 10_000_000; // Core clock rate
	localparam int DETECT_BASE_MS = 1; // Shortest detection period
	localparam int MS_CYCLES = CORE_CLK_HZ / 1000 * DETECT_BASE_MS;
	localparam logic [9:0] INSERT_BASE_MS = 10'h010; // 16 ms at code 0
	localparam logic [2:0] INSERT_MAX_CODE = 3'h5; // 512 ms
	localparam logic [2:0] INSERT_NONE_CODE = 3'h7; // No debounce
	localparam logic [1:0] PHONE_DEB_COUNT = 2'h3;
	localparam logic [9:0] REMOVAL_COUNT_SLOW = 10'h005;
	localparam logic [9:0] REMOVAL_COUNT_FAST = 10'h003;
	localparam logic [1:0] HOOK_MIN_COUNT_CODE = 2'h2;
	localparam logic [1:0] DET_PERIOD_1MS = 2'h0;
	localparam logic [1:0] DET_PERIOD_2MS = 2'h1;

	// ----------------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_USER,
		PWR_AUTO,
		PWR_AUTO_UP,
		PWR_RESERVED
	} activity_power_mode_e;

	typedef struct packed {
		logic rsvd7;
		logic phone_detect_debounce;
		logic [2:0] insert_debounce_time;
		logic removal_debounce_count;
		logic [1:0] hook_debounce_count;
	} jack_debounce_s;

	typedef struct packed {
		activity_power_mode_e activity_power_mode;
		logic [1:0] activity_monitor_channel;
		logic dataout_irq_enable;
		logic rsvd2;
		logic detect_during_record;
		logic rsvd0;
	} activity_cfg_s;

endpackage : jack_pkg

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top import jack_pkg::*;;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, jack = 0, mic = 0, hook = 0, ev = 0;
	logic idle = 0, rec = 0, pu = 0, pd = 0, sd = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic [1:0] kind = 2'h0, mon, tone;
	logic adc, hookp, dout, oe, irq;
	int fail_count = 0, num_checks = 0, cyc = 0;
	// ----------------------------------------------------------------
	// Clock, reset and hang guard
	// ----------------------------------------------------------------
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin // Far beyond the few hundred cycles needed
			fail_count++;
			results();
		end
	end
	jack_detect_and_activity_cfg #(.MS_CYCLES_P(4)) i_dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
		.I_ADDR(addr), .I_WR_DATA(wdata), .I_WR_STB(wr), .I_RD_STB(rd), .I_JACK_PRESENT(jack),
		.I_MIC_PRESENT(mic), .I_HEADSET_KIND(kind), .I_HOOK_RAW(hook), .I_ACTIVITY_EVENT(ev),
		.I_ACTIVITY_IDLE(idle), .I_RECORDING(rec), .I_USER_POWER_UP(pu),
		.I_USER_POWER_DOWN(pd), .I_SERIAL_DATA(sd), .O_RD_DATA(rdata),
		.O_MONITOR_CHANNEL(mon), .O_TONE_CHANNEL(tone), .O_ADC_POWER_UP(adc),
		.O_HOOK_PRESSED(hookp), .O_DOUT(dout), .O_DOUT_OE(oe), .O_IRQ(irq));
	// ----------------------------------------------------------------
	// Compare and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrr
	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rdc
	// One-cycle pulse on {power down, power up, idle, activity}
	task automatic pulse_ev(input logic [3:0] p);
		@(posedge clk);
		{pd, pu, idle, ev} <= p;
		@(posedge clk);
		{pd, pu, idle, ev} <= 4'h0;
		repeat (3) @(posedge clk);
		#1;
	endtask : pulse_ev
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdc(ADDR_ACTIVITY, 8'h20);
		rdc(ADDR_TONE, 8'h80);
		rdc(ADDR_JACK_STATUS, 8'h00);
		chk({6'h00, mon}, 8'h02);
		$display("reset values done");
	endtask : t_reset
	task automatic t_regs();
		wrr(ADDR_ACTIVITY, 8'hBA);
		rdc(ADDR_ACTIVITY, 8'hBA);
		chk({6'h00, mon}, 8'h03);
		wrr(ADDR_TONE, 8'hC0);
		rdc(ADDR_TONE, 8'hC0);
		chk({6'h00, tone}, 8'h03);
		wrr(ADDR_TONE, 8'h40);
		#1 chk({6'h00, tone}, 8'h01);
		wrr(ADDR_JACK_STATUS, 8'hF0);
		rdc(ADDR_JACK_STATUS, 8'h00);
		rdc(8'h55, 8'h00);
		$display("register access done");
	endtask : t_regs
	task automatic t_activity();
		wrr(ADDR_IRQ_MASK, 8'h10);
		wrr(ADDR_ACTIVITY, 8'h48); // Auto power, data-out interrupt on
		pulse_ev(4'h1);
		chk({5'h00, irq, oe, dout}, 8'h07);
		chk({7'h00, adc}, 8'h01);
		rdc(ADDR_IRQ_STATUS, 8'h10);
		#1 chk({7'h00, irq}, 8'h00);
		@(posedge clk);
		rec <= 1'b1; // Detection must stay quiet while recording
		pulse_ev(4'h1);
		rdc(ADDR_IRQ_STATUS, 8'h00);
		@(posedge clk);
		rec <= 1'b0;
		pulse_ev(4'h2); // Idle ends the automatic power-up
		chk({7'h00, adc}, 8'h00);
		wrr(ADDR_ACTIVITY, 8'h88); // Power-up on activity only
		pulse_ev(4'h1);
		pulse_ev(4'h2);
		chk({7'h00, adc}, 8'h01);
		pulse_ev(4'h8);
		chk({7'h00, adc}, 8'h00);
		rdc(ADDR_IRQ_STATUS, 8'h10);
		wrr(ADDR_ACTIVITY, 8'h0A); // User power, detection while recording
		@(posedge clk);
		rec <= 1'b1;
		pulse_ev(4'h5);
		chk({7'h00, adc}, 8'h01);
		chk({5'h00, irq, oe, dout}, 8'h06);
		rdc(ADDR_IRQ_STATUS, 8'h10);
		@(posedge clk);
		sd <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk({5'h00, irq, oe, dout}, 8'h03);
		pulse_ev(4'h8);
		chk({7'h00, adc}, 8'h00);
		@(posedge clk);
		rec <= 1'b0;
		sd <= 1'b0;
		$display("activity done");
	endtask : t_activity
	task automatic t_jack();
		wrr(ADDR_DETECT_CTRL, 8'h02);
		wrr(ADDR_DEBOUNCE, 8'h03); // Insertion 16 ms, hook after three detections
		jack <= 1'b1;
		mic <= 1'b1;
		kind <= 2'h3;
		repeat (40) @(posedge clk);
		rdc(ADDR_JACK_STATUS, 8'h00);
		repeat (60) @(posedge clk);
		rdc(ADDR_JACK_STATUS, 8'hF0);
		@(posedge clk);
		hook <= 1'b1;
		repeat (30) @(posedge clk);
		#1 chk({7'h00, hookp}, 8'h01);
		wrr(ADDR_CLOCK_CFG, 8'h04); // Four millisecond detection period
		jack <= 1'b0;
		hook <= 1'b0;
		// At 1 ms the removal would already be through here
		repeat (40) @(posedge clk);
		rdc(ADDR_JACK_STATUS, 8'hF0);
		repeat (80) @(posedge clk);
		rdc(ADDR_JACK_STATUS, 8'h00);
		rdc(ADDR_IRQ_STATUS, 8'h0F);
		$display("jack detection done");
	endtask : t_jack
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_activity();
		t_jack();
		results();
	end
endmodule : tb_top
